// >>> verilog/gdfp_top.sv
/*
 gdfp_top: three-phase gate driver fault protection.
 Assumes comparator and supply levels arrive as digital inputs on ref_clk.
*/
`timescale 1ns/100ps
module gdfp_top
    import gdfp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // drive inputs per phase
    input wire logic [2:0] high_side_drive_in,
    input wire logic [2:0] low_side_drive_in,
    // configuration
    input wire logic interlock_disable,
    input wire logic min_deadtime_en,
    input wire logic [1:0] overvoltage_deglitch_select,
    input wire logic ready_on_undervoltage_en,
    input wire logic fault_clear_all,
    // comparators
    input wire logic overvoltage_threshold_ref_dis,
    input wire logic [2:0] ls_over_cmp,
    input wire logic [2:0] hs_over_cmp,
    input wire logic supply_above_on,
    input wire logic supply_below_off,
    input wire logic [2:0] boot_uv_cmp,
    // gate outputs
    output logic [2:0] high_side_gate_out,
    output logic [2:0] low_side_gate_out,
    // status
    output logic fault_latched,
    output logic undervoltage_lockout,
    output logic ready_out,
    output logic ready_oe_n
);
    import gdfp_pkg::*;
    logic [2:0] ls_s1_r, ls_s2_r, hs_s1_r, hs_s2_r, bt_s1_r, bt_s2_r;
    logic [2:0] hs_exp, ls_exp, ov_det;
    logic dis_s1_r, dis_s2_r, on_s1_r, on_s2_r, off_s1_r, off_s2_r;
    logic uv_r;
    gdfp_state_t state_r;
    logic [CNT_W-1:0] deg_limit, frst_cnt_r;
    logic [1:0] deg_sel_r;
    logic any_ov, inputs_idle, frst_done;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ls_s1_r <= 3'h0;
            ls_s2_r <= 3'h0;
            hs_s1_r <= 3'h0;
            hs_s2_r <= 3'h0;
            bt_s1_r <= 3'h7;
            bt_s2_r <= 3'h7;
            dis_s1_r <= 1'b0;
            dis_s2_r <= 1'b0;
            on_s1_r <= 1'b0;
            on_s2_r <= 1'b0;
            off_s1_r <= 1'b1;
            off_s2_r <= 1'b1;
        end else begin
            ls_s1_r <= ls_over_cmp;
            ls_s2_r <= ls_s1_r;
            hs_s1_r <= hs_over_cmp;
            hs_s2_r <= hs_s1_r;
            bt_s1_r <= boot_uv_cmp;
            bt_s2_r <= bt_s1_r;
            dis_s1_r <= overvoltage_threshold_ref_dis;
            dis_s2_r <= dis_s1_r;
            on_s1_r <= supply_above_on;
            on_s2_r <= on_s1_r;
            off_s1_r <= supply_below_off;
            off_s2_r <= off_s1_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst)
            uv_r <= 1'b1;
        else if (uv_r && on_s2_r)
            uv_r <= 1'b0;
        else if (!uv_r && off_s2_r)
            uv_r <= 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (srst)
            deg_sel_r <= DEG_SEL_RST;
        else
            deg_sel_r <= overvoltage_deglitch_select;
    end
    always_comb begin
        case (deg_sel_r)
            2'h0: deg_limit = CNT_W'(DEG_CYC_00);
            2'h1: deg_limit = CNT_W'(DEG_CYC_01);
            2'h2: deg_limit = CNT_W'(DEG_CYC_10);
            default: deg_limit = CNT_W'(DEG_CYC_11);
        endcase
    end

    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_ph
            gdfp_phase u_ph (
                .ref_clk(ref_clk),
                .srst(srst),
                .hs_in(high_side_drive_in[p]),
                .ls_in(low_side_drive_in[p]),
                .interlock_disable(interlock_disable),
                .min_deadtime_en(min_deadtime_en),
                .uv_active(uv_r),
                .deg_limit(deg_limit),
                .mon_en(!dis_s2_r),
                .ls_over(ls_s2_r[p]),
                .hs_over(hs_s2_r[p]),
                .hs_exp(hs_exp[p]),
                .ls_exp(ls_exp[p]),
                .ov_det(ov_det[p])
            );
        end
    endgenerate

    assign any_ov = |ov_det;
    assign inputs_idle = (high_side_drive_in == 3'h0) &&
        (low_side_drive_in == 3'h0);

    always_ff @(posedge ref_clk) begin
        if (srst || !inputs_idle)
            frst_cnt_r <= '0;
        else if (!frst_done)
            frst_cnt_r <= frst_cnt_r + 1'b1;
    end
    assign frst_done = frst_cnt_r >= CNT_W'(FRST_CYC);

    always_ff @(posedge ref_clk) begin
        if (srst)
            state_r <= GDFP_RUN;
        else begin
            case (state_r)
                GDFP_RUN:
                    if (any_ov)
                        state_r <= GDFP_FAULT;
                GDFP_FAULT:
                    if (!any_ov && (frst_done || fault_clear_all))
                        state_r <= GDFP_RUN;
                default:
                    state_r <= GDFP_FAULT;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || any_ov || state_r == GDFP_FAULT || uv_r) begin
            high_side_gate_out <= 3'h0;
            low_side_gate_out <= 3'h0;
        end else begin
            // boot uv gates its own output only
            high_side_gate_out <= hs_exp & ~bt_s2_r;
            low_side_gate_out <= ls_exp;
        end
    end

    assign fault_latched = (state_r == GDFP_FAULT);
    assign undervoltage_lockout = uv_r;
    assign ready_out = 1'b0;
    assign ready_oe_n = !(uv_r && ready_on_undervoltage_en);

    // detection latches and clears outputs next edge
    a_fault_latch: assert property (
        @(posedge ref_clk) disable iff (srst)
        any_ov |=> fault_latched && high_side_gate_out == 3'h0 &&
        low_side_gate_out == 3'h0) else $error("fault not latched");
    a_fault_hold: assert property (
        @(posedge ref_clk) disable iff (srst)
        fault_latched |-> high_side_gate_out == 3'h0 &&
        low_side_gate_out == 3'h0) else $error("output on in fault");
    a_uv_low: assert property (
        @(posedge ref_clk) disable iff (srst)
        $past(uv_r) |-> high_side_gate_out == 3'h0 &&
        low_side_gate_out == 3'h0) else $error("output on in uv");
    a_uv_exit: assert property (
        @(posedge ref_clk) disable iff (srst)
        $fell(uv_r) |-> $past(on_s2_r)) else $error("uv exit early");
    a_uv_entry: assert property (
        @(posedge ref_clk) disable iff (srst)
        $rose(uv_r) |-> $past(off_s2_r)) else $error("uv entry early");
    a_sw_clear: assert property (
        @(posedge ref_clk) disable iff (srst)
        fault_latched && fault_clear_all && !any_ov |=> !fault_latched)
        else $error("clear ignored");
    // idle inputs release fault after reset time
    a_idle_clear: assert property (
        @(posedge ref_clk) disable iff (srst)
        fault_latched && frst_done && !any_ov |=> !fault_latched)
        else $error("idle clear ignored");
    // disabled monitor never latches a fault
    a_mon_dis: assert property (
        @(posedge ref_clk) disable iff (srst)
        dis_s2_r && !fault_latched |=> !fault_latched)
        else $error("monitor not disabled");
    a_ready_en: assert property (
        @(posedge ref_clk) disable iff (srst)
        !ready_oe_n |-> ready_on_undervoltage_en && uv_r)
        else $error("ready pulled wrongly");
    // boot uv turns off its own high side
    a_boot_uv_off: assert property (
        @(posedge ref_clk) disable iff (srst)
        ($past(bt_s2_r) & high_side_gate_out) == 3'h0)
        else $error("boot uv high side on");
    a_gate_follow: assert property (
        @(posedge ref_clk) disable iff (srst)
        !$past(any_ov || fault_latched || uv_r) |->
        high_side_gate_out == ($past(hs_exp) & ~$past(bt_s2_r)) &&
        low_side_gate_out == $past(ls_exp))
        else $error("gate outputs off track");
endmodule

// >>> common/gdfp_pkg.sv
/*
 gdfp_pkg: constants and types for the gate driver fault protection block.
 Assumes a single 250 MHz clock and comparator levels already digital.
*/
// How it works
// - low-side overvoltage after deglitch sets fault
// - high-side overvoltage after deglitch sets fault
// - fault forces all six outputs low
// - fault clears by idle inputs or clear
// - monitor uses expected gate state
// - glitches shorter than deglitch are ignored
// - deglitch select picks 6/4/3/2 us
// - threshold above disable limit disables monitor
// - supply undervoltage holds all outputs low
// - undervoltage exit and entry use hysteresis
// - bootstrap undervoltage turns off own high-side
// - bootstrap undervoltage unreported, may trip monitor
// - ready pulled low only when enabled
// - high input commands switch on
// - interlock turns both-high into both-off
// - dead time inserted unless disabled
package gdfp_pkg;
    localparam int CLK_MHZ = 250;
    localparam int DEG_US_00 = 6;
    localparam int DEG_US_01 = 4;
    localparam int DEG_US_10 = 3;
    localparam int DEG_US_11 = 2;
    localparam int DEG_CYC_00 = DEG_US_00 * CLK_MHZ;
    localparam int DEG_CYC_01 = DEG_US_01 * CLK_MHZ;
    localparam int DEG_CYC_10 = DEG_US_10 * CLK_MHZ;
    localparam int DEG_CYC_11 = DEG_US_11 * CLK_MHZ;
    localparam int DEAD_NS = 100;
    localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int FRST_US = 10;
    localparam int FRST_CYC = FRST_US * CLK_MHZ;
    localparam int CNT_W = 12;
    localparam logic [1:0] DEG_SEL_RST = 2'h0;
    typedef enum logic [1:0] {
        GDFP_RUN = 2'b01,
        GDFP_FAULT = 2'b10
    } gdfp_state_t;
endpackage

// >>> verilog/gdfp_phase.sv
/*
 gdfp_phase: expected gate state and overvoltage deglitch for one phase.
 Assumes synchronised comparator inputs and a common deglitch limit.
*/
`timescale 1ns/100ps
module gdfp_phase
    import gdfp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // drive inputs
    input wire logic hs_in,
    input wire logic ls_in,
    // configuration
    input wire logic interlock_disable,
    input wire logic min_deadtime_en,
    input wire logic uv_active,
    input wire logic [gdfp_pkg::CNT_W-1:0] deg_limit,
    input wire logic mon_en,
    // comparator levels
    input wire logic ls_over,
    input wire logic hs_over,
    // results
    output logic hs_exp,
    output logic ls_exp,
    output logic ov_det
);
    import gdfp_pkg::*;
    logic hs_cmd, ls_cmd, dt_on;
    logic [CNT_W-1:0] dt_cnt_r, hs_cnt_r, ls_cnt_r;
    logic prev_hs_r, prev_ls_r;
    logic hs_ok, ls_ok;

    assign hs_cmd = hs_in && (interlock_disable || !ls_in);
    assign ls_cmd = ls_in && (interlock_disable || !hs_in);
    assign dt_on = min_deadtime_en && !interlock_disable;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dt_cnt_r <= '0;
            prev_hs_r <= 1'b0;
            prev_ls_r <= 1'b0;
        end else begin
            prev_hs_r <= hs_exp;
            prev_ls_r <= ls_exp;
            if ((prev_hs_r && !hs_exp) || (prev_ls_r && !ls_exp))
                dt_cnt_r <= CNT_W'(DEAD_CYC);
            else if (dt_cnt_r != '0)
                dt_cnt_r <= dt_cnt_r - 1'b1;
        end
    end

    assign hs_ok = !(dt_on && (dt_cnt_r != '0 || prev_ls_r));
    assign ls_ok = !(dt_on && (dt_cnt_r != '0 || prev_hs_r));
    assign hs_exp = hs_cmd && !uv_active && (hs_ok || prev_hs_r);
    assign ls_exp = ls_cmd && !uv_active && (ls_ok || prev_ls_r);

    always_ff @(posedge ref_clk) begin
        if (srst || !mon_en || !ls_exp || !ls_over)
            ls_cnt_r <= '0;
        else if (ls_cnt_r <= deg_limit)
            ls_cnt_r <= ls_cnt_r + 1'b1;
    end
    always_ff @(posedge ref_clk) begin
        if (srst || !mon_en || !hs_exp || !hs_over)
            hs_cnt_r <= '0;
        else if (hs_cnt_r <= deg_limit)
            hs_cnt_r <= hs_cnt_r + 1'b1;
    end
    assign ov_det = mon_en &&
        ((ls_cnt_r > deg_limit) || (hs_cnt_r > deg_limit));

    // detection only after a full deglitch run
    a_no_early_det: assert property (
        @(posedge ref_clk) disable iff (srst)
        $rose(ov_det) && $stable(deg_limit) |->
        $past(ls_exp && ls_over && ls_cnt_r == deg_limit) ||
        $past(hs_exp && hs_over && hs_cnt_r == deg_limit))
        else $error("early overvoltage detect");
    a_interlock_off: assert property (
        @(posedge ref_clk) disable iff (srst)
        (hs_in && ls_in && !interlock_disable) |-> !hs_exp && !ls_exp)
        else $error("interlock violated");
    // high side held off after low side off
    a_dead_gap: assert property (
        @(posedge ref_clk) disable iff (srst)
        dt_on && $fell(ls_exp) |=> (!hs_exp) [*8])
        else $error("dead time skipped");
endmodule

// >>> test/gdfp_pwm_model.sv
/*
 gdfp_pwm_model: controller timer driving the six drive inputs.
 Assumes the bench sets the wanted pattern; pins move on falling edges.
*/
`timescale 1ns/100ps
module gdfp_pwm_model (
    // clock
    input wire logic ref_clk,
    // wanted pattern and pacing
    input wire logic [2:0] want_hs,
    input wire logic [2:0] want_ls,
    input wire logic slow,
    // drive pins
    output logic [2:0] hs_pin,
    output logic [2:0] ls_pin
);
    logic [5:0] stage_r;
    initial {hs_pin, ls_pin, stage_r} = 12'h000;
    always @(negedge ref_clk) begin
        stage_r <= {want_hs, want_ls};
        {hs_pin, ls_pin} <= slow ? stage_r : {want_hs, want_ls};
    end
endmodule

// >>> test/test_gdfp_top.sv
/*
 test_gdfp_top: self-checking bench for the fault protection block.
 Assumes the timer model drives the inputs; the rest change on falling edges.
*/
`timescale 1ns/100ps
module test_gdfp_top;
    import gdfp_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] w_hs = 3'h0, w_ls = 3'h0, hs_in, ls_in, hs_o, ls_o;
    logic [2:0] ls_c = 3'h0, hs_c = 3'h0, b_uv = 3'h0;
    logic slow = 1'b0, ild = 1'b0, mdt = 1'b1, r_en = 1'b1, clr = 1'b0;
    logic dis = 1'b0, above = 1'b0, below = 1'b1;
    logic [1:0] sel = 2'h0;
    logic fault, uv, rdy, oe_n;
    int fail_count = 0;
    int tests_run = 0;
    int us [4] = '{DEG_US_00, DEG_US_01, DEG_US_10, DEG_US_11};
    int lim;
    always #2 ref_clk = ~ref_clk;

    gdfp_pwm_model pwm (.ref_clk(ref_clk), .want_hs(w_hs), .want_ls(w_ls),
        .slow(slow), .hs_pin(hs_in), .ls_pin(ls_in));

    gdfp_top uut (.ref_clk(ref_clk), .srst(srst),
        .high_side_drive_in(hs_in), .low_side_drive_in(ls_in),
        .interlock_disable(ild), .min_deadtime_en(mdt),
        .overvoltage_deglitch_select(sel), .ready_on_undervoltage_en(r_en),
        .fault_clear_all(clr), .overvoltage_threshold_ref_dis(dis),
        .ls_over_cmp(ls_c), .hs_over_cmp(hs_c), .supply_above_on(above),
        .supply_below_off(below), .boot_uv_cmp(b_uv),
        .high_side_gate_out(hs_o), .low_side_gate_out(ls_o),
        .fault_latched(fault), .undervoltage_lockout(uv),
        .ready_out(rdy), .ready_oe_n(oe_n));

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic chk(input string nm, input logic [5:0] e,
        input logic [5:0] s);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic drv(input logic [2:0] h, input logic [2:0] l, input int n);
        w_hs <= h;
        w_ls <= l;
        cyc(n);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wait_fault(input logic v, input int n);
        int k;
        k = 0;
        while (fault !== v && k < n) begin
            cyc(1);
            k++;
        end
        chk("fault wait", {5'h00, v}, {5'h00, fault});
        if (fault !== v) conclude();
    endtask

    initial begin
        cyc(20);
        srst = 1'b0;
        cyc(1);
        chk("reset status", 6'h02, {3'h0, fault, uv, oe_n});
        chk("reset gates", 6'h00, {hs_o, ls_o});
        chk("ready level", 6'h00, {5'h00, rdy});
        r_en = 1'b0;
        cyc(2);
        chk("ready off", 6'h03, {3'h0, fault, uv, oe_n});
        r_en = 1'b1;
        above = 1'b1;
        below = 1'b0;
        cyc(6);
        chk("uv exit", 6'h01, {3'h0, fault, uv, oe_n});
        above = 1'b0;
        cyc(6);
        chk("uv hysteresis", 6'h01, {3'h0, fault, uv, oe_n});
        for (int i = 0; i < 8; i++) begin
            ild = i[2];
            slow = i[2];
            drv(3'h0, 3'h0, 40);
            drv({3{i[1]}}, {3{i[0]}}, 40);
            chk("table", {{3{i[1] & (ild | ~i[0])}},
                {3{i[0] & (ild | ~i[1])}}}, {hs_o, ls_o});
        end
        ild = 1'b0;
        slow = 1'b0;
        drv(3'h7, 3'h0, 40);
        drv(3'h0, 3'h7, 12);
        chk("dead time", 6'h00, {hs_o, ls_o});
        cyc(30);
        chk("after dead", 6'h07, {hs_o, ls_o});
        mdt = 1'b0;
        drv(3'h7, 3'h0, 40);
        drv(3'h0, 3'h7, 6);
        chk("no dead time", 6'h07, {hs_o, ls_o});
        mdt = 1'b1;
        for (int i = 0; i < 4; i++) begin
            sel = i[1:0];
            lim = us[i] * CLK_MHZ;
            drv(i[0] ? 3'h2 : 3'h0, i[0] ? 3'h0 : 3'h2, 40);
            ls_c[1] = ~i[0];
            hs_c[1] = i[0];
            cyc(lim - 40);
            ls_c = 3'h0;
            hs_c = 3'h0;
            cyc(10);
            chk("glitch", 6'h00, {5'h00, fault});
            ls_c[1] = ~i[0];
            hs_c[1] = i[0];
            cyc(lim - 20);
            chk("early", 6'h00, {5'h00, fault});
            wait_fault(1'b1, 80);
            chk("forced off", 6'h00, {hs_o, ls_o});
            ls_c = 3'h0;
            hs_c = 3'h0;
            cyc(4);
            if (i < 3) begin
                clr = 1'b1;
                cyc(1);
                clr = 1'b0;
                cyc(2);
                chk("clear", 6'h00, {5'h00, fault});
            end else begin
                drv(3'h0, 3'h0, FRST_CYC - 100);
                chk("idle early", 6'h01, {5'h00, fault});
                wait_fault(1'b0, 300);
            end
        end
        drv(3'h2, 3'h0, 40);
        ls_c[1] = 1'b1;
        cyc(700);
        ls_c = 3'h0;
        cyc(4);
        chk("expected state", 6'h00, {5'h00, fault});
        dis = 1'b1;
        drv(3'h0, 3'h1, 40);
        ls_c[0] = 1'b1;
        cyc(700);
        ls_c = 3'h0;
        cyc(4);
        chk("monitor off", 6'h00, {5'h00, fault});
        dis = 1'b0;
        drv(3'h3, 3'h0, 40);
        b_uv[1] = 1'b1;
        cyc(6);
        chk("boot uv", 6'h08, {hs_o, ls_o});
        hs_c[1] = 1'b1;
        wait_fault(1'b1, lim + 40);
        chk("boot uv trip", 6'h00, {hs_o, ls_o});
        hs_c = 3'h0;
        cyc(4);
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        b_uv = 3'h0;
        drv(3'h0, 3'h0, 4);
        drv(3'h0, 3'h7, 40);
        below = 1'b1;
        cyc(6);
        chk("uv entry", 6'h02, {3'h0, fault, uv, oe_n});
        chk("uv gates", 6'h00, {hs_o, ls_o});
        conclude();
    end
endmodule
